// ==== common/fmbc_pkg.sv ====
// shared constants and types for the flash mode and boot configuration block
`default_nettype none
package fmbc_pkg;
	// ----------------------------------------------------------------
	// register map (byte addresses on the apb bus, plus the option byte's flash address)
	// ----------------------------------------------------------------
	localparam logic [11:0] OPT_BYTE_FLASH_ADDR = 12'h07a;
	localparam logic [11:0] ADDR_OPTION = 12'h07c;
	localparam logic [11:0] ADDR_MODE_STAT = 12'h000;
	localparam logic [11:0] ADDR_SELF_CTRL = 12'h004;
	localparam logic [11:0] ADDR_VEC_STAT = 12'h008;
	localparam logic [11:0] ADDR_RAM_BASE = 12'h00c;
	// ----------------------------------------------------------------
	// reset values and figures
	// ----------------------------------------------------------------
	localparam logic [7:0] OPTION_RESET = 8'h00;
	localparam logic [31:0] RAM_BASE_RESET = 32'h03ff_f000;
	localparam logic [31:0] MI_VEC_OFFSET = 32'h0000_0004;
	localparam int MAX_MODE_PULSES = 12;
	localparam logic [3:0] PULSES_ASYNC = 4'h0;
	localparam logic [3:0] PULSES_SYNC = 4'h8;
	localparam logic [3:0] PULSES_SYNC_HS = 4'hb;
	localparam int SEL_WINDOW_NS = 100000;
	localparam int CLK_NS = 50;
	localparam int SEL_WINDOW_CYC = SEL_WINDOW_NS / CLK_NS;
	localparam int SELF_CTRL_EN_BIT = 0;
	localparam int SELF_CTRL_SWAP_BIT = 1;
	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_NORMAL = 2'b00,
		MODE_PROG = 2'b01,
		MODE_BAD = 2'b10
	} fmbc_mode_t;
	typedef enum logic [1:0] {
		IF_NONE = 2'b00,
		IF_ASYNC = 2'b01,
		IF_SYNC = 2'b10,
		IF_SYNC_HS = 2'b11
	} fmbc_if_t;
	typedef struct packed {
		logic async_tx;
		logic async_rx;
		logic sync_out;
		logic sync_in;
		logic sync_clk;
		logic handshake;
	} fmbc_pins_t;
endpackage : fmbc_pkg
`default_nettype wire

// ==== logic/fmbc_top.sv ====
// mode select, programming pin routing, boot swap, ram vectors and option byte
// How it works
// RULE1 - mode pin0 low gives normal; pin0 high pin1 low gives programming; both high prohibited
// RULE2 - handshake mode uses out, in, clock, handshake; async tx/rx; clocked without handshake
// RULE3 - in programming mode every unused pin keeps its post-reset state
// RULE4 - system must not assert reset during programming; only the programmer resets
// RULE5 - debug reset input kept low or open during programming, never driven high
// RULE6 - boot swap exchanges blocks 0,1 with blocks 2,3
// RULE7 - no instruction fetch from flash during self programming
// RULE8 - nmi vectors to internal ram start during self programming
// RULE9 - maskable interrupt vectors to ram start plus 4 during self programming
// RULE10 - flash writes blocked while mode pin0 low
// RULE11 - option configuration is the 8-bit byte at flash address 7a
// RULE12 - option byte cannot be altered by the running program
// RULE13 - up to 12 pulses on mode pin0 select the serial interface
// RULE14 - mode pins and option byte captured once at reset release, held until reset
//
// Added by the designer: register access over APB.
`default_nettype none
module fmbc_top #(
	parameter int SEL_WINDOW = fmbc_pkg::SEL_WINDOW_CYC
) (
	input wire logic MCLK,
	input wire logic ARST_N,
	input wire logic MODE_SELECT_PIN0,
	input wire logic MODE_SELECT_PIN1,
	input wire logic DEBUG_RESET_PIN,
	input wire logic [7:0] FLASH_OPT_DATA,
	output logic [11:0] FLASH_OPT_ADDR,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	output logic PROG_MODE,
	output logic [1:0] PROG_IF,
	output logic [5:0] PIN_OWNED,
	output logic PORT_DEFAULT,
	output logic BOOT_SWAP,
	output logic FETCH_BLOCK,
	output logic FLASH_WR_EN,
	output logic [31:0] NMI_VECTOR,
	output logic [31:0] MI_VECTOR,
	output logic [7:0] OPTION_BYTE
);
	if (SEL_WINDOW < 2) begin : g_bad_window
		$error("SEL_WINDOW too small");
	end
	// ----------------------------------------------------------------
	// reset and pin synchronisers
	// ----------------------------------------------------------------
	logic [1:0] rst_sync;
	logic rst_n;
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) rst_sync <= 2'b00;
		else rst_sync <= {rst_sync[0], 1'b1};
	end
	assign rst_n = rst_sync[1];
	logic [2:0] pin_s1;
	logic [2:0] pin_s2;
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1 <= 3'h0;
			pin_s2 <= 3'h0;
		end else begin
			pin_s1 <= {DEBUG_RESET_PIN, MODE_SELECT_PIN1, MODE_SELECT_PIN0};
			pin_s2 <= pin_s1;
		end
	end
	logic md0;
	logic md1;
	logic debug_reset_pin;
	assign md0 = pin_s2[0];
	assign md1 = pin_s2[1];
	assign debug_reset_pin = pin_s2[2];
	// ----------------------------------------------------------------
	// one-time capture after reset release
	// ----------------------------------------------------------------
	// pins need two edges to settle through the synchroniser; capture on the third
	logic [1:0] cap_cnt;
	logic captured;
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) cap_cnt <= 2'h0;
		else if (!captured) cap_cnt <= cap_cnt + 2'h1;
	end
	logic cap_now;
	assign cap_now = !captured && (cap_cnt == 2'h2);
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) captured <= 1'b0;
		else if (cap_now) captured <= 1'b1; // see RULE14
	end
	fmbc_pkg::fmbc_mode_t mode;
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) mode <= fmbc_pkg::MODE_NORMAL;
		else if (cap_now) begin // see RULE14
			if (!md0) mode <= fmbc_pkg::MODE_NORMAL; // see RULE1
			else if (!md1) mode <= fmbc_pkg::MODE_PROG; // see RULE1
			else mode <= fmbc_pkg::MODE_BAD; // see RULE1
		end
	end
	// option byte is read from the flash image only; no bus path writes it
	assign FLASH_OPT_ADDR = fmbc_pkg::OPT_BYTE_FLASH_ADDR; // see RULE11
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) OPTION_BYTE <= fmbc_pkg::OPTION_RESET;
		else if (cap_now) OPTION_BYTE <= FLASH_OPT_DATA; // see RULE12
	end
	// ----------------------------------------------------------------
	// communication mode selection by pulses on mode pin0
	// ----------------------------------------------------------------
	logic md0_q;
	logic [3:0] pulse_cnt;
	logic [$clog2(SEL_WINDOW+1)-1:0] win_cnt;
	logic sel_done;
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) md0_q <= 1'b0;
		else md0_q <= md0;
	end
	logic md0_rise;
	assign md0_rise = md0 && !md0_q && (mode == fmbc_pkg::MODE_PROG) && !sel_done;
	// pulses are counted up to the limit; extra ones are ignored
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) pulse_cnt <= 4'h0;
		else if (md0_rise && pulse_cnt < 4'(fmbc_pkg::MAX_MODE_PULSES))
			pulse_cnt <= pulse_cnt + 4'h1; // see RULE13
	end
	// window restarts on each pulse; selection closes once the line stays quiet
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) win_cnt <= '0;
		else if (md0_rise) win_cnt <= '0;
		else if (mode == fmbc_pkg::MODE_PROG && !sel_done) win_cnt <= win_cnt + 1'b1;
	end
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) sel_done <= 1'b0;
		else if (mode == fmbc_pkg::MODE_PROG && !md0_rise
			&& win_cnt == ($bits(win_cnt))'(SEL_WINDOW - 1))
			sel_done <= 1'b1;
	end
	fmbc_pkg::fmbc_if_t prog_if;
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) prog_if <= fmbc_pkg::IF_NONE;
		else if (mode == fmbc_pkg::MODE_PROG && !md0_rise && !sel_done
			&& win_cnt == ($bits(win_cnt))'(SEL_WINDOW - 1)) begin
			if (pulse_cnt >= fmbc_pkg::PULSES_SYNC_HS) prog_if <= fmbc_pkg::IF_SYNC_HS; // see RULE13
			else if (pulse_cnt >= fmbc_pkg::PULSES_SYNC) prog_if <= fmbc_pkg::IF_SYNC;
			else prog_if <= fmbc_pkg::IF_ASYNC;
		end
	end
	// ----------------------------------------------------------------
	// serial pin ownership
	// ----------------------------------------------------------------
	fmbc_pkg::fmbc_pins_t owned;
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) owned <= '0;
		else begin
			owned <= '0; // see RULE3
			case (prog_if)
				fmbc_pkg::IF_ASYNC: begin
					owned.async_tx <= 1'b1; // see RULE2
					owned.async_rx <= 1'b1;
				end
				fmbc_pkg::IF_SYNC: begin
					owned.sync_out <= 1'b1; // see RULE2
					owned.sync_in <= 1'b1;
					owned.sync_clk <= 1'b1;
				end
				fmbc_pkg::IF_SYNC_HS: begin
					owned.sync_out <= 1'b1; // see RULE2
					owned.sync_in <= 1'b1;
					owned.sync_clk <= 1'b1;
					owned.handshake <= 1'b1;
				end
				default: owned <= '0;
			endcase
		end
	end
	assign PIN_OWNED = owned;
	assign PROG_MODE = (mode == fmbc_pkg::MODE_PROG);
	assign PROG_IF = prog_if;
	// all non-programming pins sit at reset state whenever programming mode is active
	assign PORT_DEFAULT = (mode == fmbc_pkg::MODE_PROG); // see RULE3
	// ----------------------------------------------------------------
	// self programming control
	// ----------------------------------------------------------------
	logic self_en;
	logic swap;
	logic [31:0] ram_base;
	logic dbg_fault;
	logic wr_setup;
	logic wr_access;
	assign wr_setup = PSEL && PENABLE && PWRITE;
	assign wr_access = wr_setup && (mode == fmbc_pkg::MODE_NORMAL);
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			self_en <= 1'b0;
			swap <= 1'b0;
		end else if (wr_access && PADDR == fmbc_pkg::ADDR_SELF_CTRL) begin
			self_en <= PWDATA[fmbc_pkg::SELF_CTRL_EN_BIT];
			swap <= PWDATA[fmbc_pkg::SELF_CTRL_SWAP_BIT]; // see RULE6
		end
	end
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) ram_base <= fmbc_pkg::RAM_BASE_RESET;
		else if (wr_access && PADDR == fmbc_pkg::ADDR_RAM_BASE) ram_base <= PWDATA;
	end
	// sticky record that the debug reset was seen high during programming
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) dbg_fault <= 1'b0;
		else if (mode == fmbc_pkg::MODE_PROG && debug_reset_pin) dbg_fault <= 1'b1; // see RULE5
	end
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			BOOT_SWAP <= 1'b0;
			FETCH_BLOCK <= 1'b0;
			FLASH_WR_EN <= 1'b0;
			NMI_VECTOR <= '0;
			MI_VECTOR <= '0;
		end else begin
			BOOT_SWAP <= swap; // see RULE6
			FETCH_BLOCK <= self_en; // see RULE7
			FLASH_WR_EN <= self_en && md0; // see RULE10
			NMI_VECTOR <= self_en ? ram_base : '0; // see RULE8
			MI_VECTOR <= self_en ? ram_base + fmbc_pkg::MI_VEC_OFFSET : '0; // see RULE9
		end
	end
	// ----------------------------------------------------------------
	// apb slave: zero wait states, unmapped addresses flag an error
	// ----------------------------------------------------------------
	logic mapped;
	logic [31:0] next_rdata;
	always_comb begin
		mapped = 1'b1;
		next_rdata = 32'h0000_0000;
		if (PADDR == fmbc_pkg::ADDR_MODE_STAT)
			next_rdata = {24'h0, dbg_fault, sel_done, prog_if, md0, mode, captured};
		else if (PADDR == fmbc_pkg::ADDR_SELF_CTRL)
			next_rdata = {30'h0, swap, self_en};
		else if (PADDR == fmbc_pkg::ADDR_VEC_STAT)
			next_rdata = {29'h0, FLASH_WR_EN, FETCH_BLOCK, BOOT_SWAP};
		else if (PADDR == fmbc_pkg::ADDR_RAM_BASE)
			next_rdata = ram_base;
		else if (PADDR == fmbc_pkg::ADDR_OPTION)
			next_rdata = {24'h0, OPTION_BYTE};
		else
			mapped = 1'b0;
	end
	assign PREADY = 1'b1;
	assign PRDATA = (PSEL && PENABLE && !PWRITE) ? next_rdata : 32'h0000_0000;
	// a write to the option address is refused: the byte comes only from flash
	assign PSLVERR = PSEL && PENABLE && (!mapped
		|| (PWRITE && PADDR == fmbc_pkg::ADDR_OPTION)); // see RULE12
	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_mode_hold;
		@(posedge MCLK) disable iff (!rst_n) captured |=> $stable(mode);
	endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("mode changed after capture"); // see RULE14
	property p_mode_decode;
		@(posedge MCLK) disable iff (!rst_n)
			cap_now && !md0 |=> mode == fmbc_pkg::MODE_NORMAL;
	endproperty
	a_mode_decode: assert property (p_mode_decode) else $error("low pin0 not normal"); // see RULE1
	property p_opt_hold;
		@(posedge MCLK) disable iff (!rst_n) captured |=> $stable(OPTION_BYTE);
	endproperty
	a_opt_hold: assert property (p_opt_hold) else $error("option byte altered"); // see RULE12
	property p_opt_addr;
		@(posedge MCLK) disable iff (!rst_n) FLASH_OPT_ADDR == 12'h07a;
	endproperty
	a_opt_addr: assert property (p_opt_addr) else $error("option address wrong"); // see RULE11
	property p_wr_block;
		@(posedge MCLK) disable iff (!rst_n) !md0 |=> !FLASH_WR_EN;
	endproperty
	a_wr_block: assert property (p_wr_block) else $error("write enabled with pin0 low"); // see RULE10
	property p_mi_vec;
		@(posedge MCLK) disable iff (!rst_n)
			self_en |=> MI_VECTOR == NMI_VECTOR + 32'h4;
	endproperty
	a_mi_vec: assert property (p_mi_vec) else $error("maskable vector offset wrong"); // see RULE9
	property p_nmi_vec;
		@(posedge MCLK) disable iff (!rst_n) self_en |=> NMI_VECTOR == $past(ram_base);
	endproperty
	a_nmi_vec: assert property (p_nmi_vec) else $error("nmi vector not ram start"); // see RULE8
	property p_fetch;
		@(posedge MCLK) disable iff (!rst_n) self_en |=> FETCH_BLOCK;
	endproperty
	a_fetch: assert property (p_fetch) else $error("flash fetch not blocked"); // see RULE7
	property p_pins_normal;
		@(posedge MCLK) disable iff (!rst_n)
			mode != fmbc_pkg::MODE_PROG |-> PIN_OWNED == 6'h00;
	endproperty
	a_pins_normal: assert property (p_pins_normal) else $error("pins taken outside prog"); // see RULE3
	property p_hs_pins;
		@(posedge MCLK) disable iff (!rst_n)
			prog_if == fmbc_pkg::IF_SYNC_HS |=> PIN_OWNED == 6'h0f;
	endproperty
	a_hs_pins: assert property (p_hs_pins) else $error("handshake pins wrong"); // see RULE2
	property p_pulse_cap;
		@(posedge MCLK) disable iff (!rst_n) pulse_cnt <= 4'hc;
	endproperty
	a_pulse_cap: assert property (p_pulse_cap) else $error("pulse count over limit"); // see RULE13
	property p_swap;
		@(posedge MCLK) disable iff (!rst_n) swap |=> BOOT_SWAP;
	endproperty
	a_swap: assert property (p_swap) else $error("swap not applied"); // see RULE6
	property p_prog_decode;
		@(posedge MCLK) disable iff (!rst_n)
			cap_now && md0 && !md1 |=> mode == fmbc_pkg::MODE_PROG;
	endproperty
	a_prog_decode: assert property (p_prog_decode) else $error("prog mode not entered"); // see RULE1
	property p_bad_mode;
		@(posedge MCLK) disable iff (!rst_n)
			cap_now && md0 && md1 |=> mode == fmbc_pkg::MODE_BAD;
	endproperty
	a_bad_mode: assert property (p_bad_mode) else $error("prohibited pins accepted"); // see RULE1
	property p_sync_pins;
		@(posedge MCLK) disable iff (!rst_n)
			prog_if == fmbc_pkg::IF_SYNC |=> PIN_OWNED == 6'h0e;
	endproperty
	a_sync_pins: assert property (p_sync_pins) else $error("clocked pins wrong"); // see RULE2
	property p_async_pins;
		@(posedge MCLK) disable iff (!rst_n)
			prog_if == fmbc_pkg::IF_ASYNC |=> PIN_OWNED == 6'h30;
	endproperty
	a_async_pins: assert property (p_async_pins) else $error("async pins wrong"); // see RULE2
	property p_if_hold;
		@(posedge MCLK) disable iff (!rst_n) sel_done |=> $stable(prog_if);
	endproperty
	a_if_hold: assert property (p_if_hold) else $error("interface changed after select"); // see RULE13
	property p_opt_refuse;
		@(posedge MCLK) disable iff (!rst_n)
			PSEL && PENABLE && PWRITE && PADDR == fmbc_pkg::ADDR_OPTION |-> PSLVERR;
	endproperty
	a_opt_refuse: assert property (p_opt_refuse) else $error("option write not refused"); // see RULE12
	property p_fetch_off;
		@(posedge MCLK) disable iff (!rst_n) !self_en |=> !FETCH_BLOCK;
	endproperty
	a_fetch_off: assert property (p_fetch_off) else $error("fetch blocked while idle"); // see RULE7
	property p_vec_off;
		@(posedge MCLK) disable iff (!rst_n)
			!self_en |=> NMI_VECTOR == 32'h0000_0000 && MI_VECTOR == 32'h0000_0000;
	endproperty
	a_vec_off: assert property (p_vec_off) else $error("ram vectors outside self prog"); // see RULE8
	c_prog: cover property (@(posedge MCLK) disable iff (!rst_n) mode == fmbc_pkg::MODE_PROG);
	c_hs: cover property (@(posedge MCLK) disable iff (!rst_n) prog_if == fmbc_pkg::IF_SYNC_HS);
	c_self: cover property (@(posedge MCLK) disable iff (!rst_n) FLASH_WR_EN);
	c_sync: cover property (@(posedge MCLK) disable iff (!rst_n) prog_if == fmbc_pkg::IF_SYNC);
	c_bad: cover property (@(posedge MCLK) disable iff (!rst_n) mode == fmbc_pkg::MODE_BAD);
endmodule : fmbc_top
`default_nettype wire

// ==== tb/fmbc_prog_model.sv ====
// behavioural model of the external flash programmer on the mode and reset pins
`default_nettype none
module fmbc_prog_model (
	input wire logic clk,
	output logic rst_n,
	output logic mode0,
	output logic mode1,
	output logic dbg_rst
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------------------------------
	// pin levels
	// ----------------------------------------------------------------
	// the debug reset line starts low and is driven high only through debug_level
	initial begin
		rst_n = 1'b0;
		mode0 = 1'b0;
		mode1 = 1'b0;
		dbg_rst = 1'b0;
	end
	// ----------------------------------------------------------------
	// actions
	// ----------------------------------------------------------------
	// only the programmer pulls reset, so no other source can disturb a session
	task hold_reset(input logic p0, input logic p1);
		@(posedge clk);
		rst_n <= 1'b0;
		mode0 <= p0;
		mode1 <= p1;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge clk);
	endtask : hold_reset
	// low then high again: three cycles each way keeps above the two-cycle minimum
	task pulses(input int n);
		repeat (n) begin
			@(posedge clk);
			mode0 <= 1'b0;
			repeat (3) @(posedge clk);
			mode0 <= 1'b1;
			repeat (2) @(posedge clk);
		end
	endtask : pulses
	// used outside programming only; inside a session the line stays low
	task debug_level(input logic v);
		@(posedge clk);
		dbg_rst <= v;
	endtask : debug_level
	task drive0(input logic v);
		@(posedge clk);
		mode0 <= v;
	endtask : drive0
endmodule : fmbc_prog_model
`default_nettype wire

// ==== tb/fmbc_top_tb.sv ====
// self-checking bench for the mode select and boot configuration block
`default_nettype none
module fmbc_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk, arst_n, mode0, mode1, dbg, psel, penable, pwrite, pready, pslverr;
	logic prog_mode, port_def, boot_swap, fetch_blk, wr_en;
	logic [7:0] opt, opt_byte;
	logic [11:0] paddr, opt_addr;
	logic [31:0] pwdata, prdata, nmi_vec, mi_vec, r;
	logic [1:0] prog_if;
	logic [5:0] pin_owned;
	logic e;
	int error_cnt = 0;
	int n_tests = 0;
	int cyc = 0;
	// ----------------------------------------------------------------
	// clock, partner and design
	// ----------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	fmbc_prog_model u_prog (.clk(mclk), .rst_n(arst_n), .mode0(mode0), .mode1(mode1),
		.dbg_rst(dbg));
	fmbc_top #(.SEL_WINDOW(20)) DUT (.MCLK(mclk), .ARST_N(arst_n), .MODE_SELECT_PIN0(mode0),
		.MODE_SELECT_PIN1(mode1), .DEBUG_RESET_PIN(dbg), .FLASH_OPT_DATA(opt),
		.FLASH_OPT_ADDR(opt_addr), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.PROG_MODE(prog_mode), .PROG_IF(prog_if), .PIN_OWNED(pin_owned),
		.PORT_DEFAULT(port_def), .BOOT_SWAP(boot_swap), .FETCH_BLOCK(fetch_blk),
		.FLASH_WR_EN(wr_en), .NMI_VECTOR(nmi_vec), .MI_VECTOR(mi_vec), .OPTION_BYTE(opt_byte));
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task results;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : results
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1 && k < 50) begin
			@(posedge mclk);
			k++;
		end
		r = prdata;
		e = pslverr;
		chk(32'(pready), 32'h1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task t_normal;
		u_prog.hold_reset(1'b0, 1'b1);
		chk(32'(prog_mode), 32'h0);
		apb(1'b0, fmbc_pkg::ADDR_MODE_STAT, 32'h0);
		chk(32'(r[2:0]), 32'({fmbc_pkg::MODE_NORMAL, 1'b1}));
		chk(32'(e), 32'h0);
		chk(32'(opt_addr), 32'(fmbc_pkg::OPT_BYTE_FLASH_ADDR));
		chk(32'(opt_byte), 32'h0000_00c3);
		apb(1'b1, fmbc_pkg::ADDR_OPTION, 32'h0000_0055);
		chk(32'(e), 32'h1);
		apb(1'b0, fmbc_pkg::ADDR_OPTION, 32'h0);
		chk(32'(r[7:0]), 32'h0000_00c3);
		apb(1'b0, 12'h040, 32'h0);
		chk(32'(e), 32'h1);
		u_prog.debug_level(1'b1);
		repeat (4) @(posedge mclk);
		apb(1'b0, fmbc_pkg::ADDR_MODE_STAT, 32'h0);
		chk(32'(r[7]), 32'h0);
		u_prog.debug_level(1'b0);
		opt <= 8'h3c;
		u_prog.drive0(1'b1);
		repeat (6) @(posedge mclk);
		#1;
		chk(32'(opt_byte), 32'h0000_00c3);
		chk(32'(prog_mode), 32'h0);
		u_prog.drive0(1'b0);
		opt <= 8'hc3;
	endtask : t_normal
	task t_self_prog;
		u_prog.hold_reset(1'b0, 1'b0);
		apb(1'b0, fmbc_pkg::ADDR_RAM_BASE, 32'h0);
		chk(r, fmbc_pkg::RAM_BASE_RESET);
		apb(1'b1, fmbc_pkg::ADDR_SELF_CTRL, 32'h0000_0003);
		@(posedge mclk);
		#1;
		chk(32'(wr_en), 32'h0);
		chk(32'(boot_swap), 32'h1);
		chk(32'(fetch_blk), 32'h1);
		chk(nmi_vec, fmbc_pkg::RAM_BASE_RESET);
		chk(mi_vec, fmbc_pkg::RAM_BASE_RESET + 32'h4);
		u_prog.drive0(1'b1);
		repeat (4) @(posedge mclk);
		#1;
		chk(32'(wr_en), 32'h1);
		u_prog.drive0(1'b0);
		repeat (4) @(posedge mclk);
		#1;
		chk(32'(wr_en), 32'h0);
		apb(1'b1, fmbc_pkg::ADDR_SELF_CTRL, 32'h0);
		@(posedge mclk);
		#1;
		chk(32'(fetch_blk), 32'h0);
		chk(nmi_vec, 32'h0);
		chk(32'(boot_swap), 32'h0);
		chk(mi_vec, 32'h0);
		apb(1'b1, fmbc_pkg::ADDR_RAM_BASE, 32'h0000_4000);
		apb(1'b1, fmbc_pkg::ADDR_SELF_CTRL, 32'h0000_0001);
		@(posedge mclk);
		#1;
		chk(nmi_vec, 32'h0000_4000);
		chk(mi_vec, 32'h0000_4000 + fmbc_pkg::MI_VEC_OFFSET);
		apb(1'b0, fmbc_pkg::ADDR_VEC_STAT, 32'h0);
		chk(32'(r[2:0]), 32'h2);
		chk(32'(e), 32'h0);
		apb(1'b1, fmbc_pkg::ADDR_SELF_CTRL, 32'h0);
	endtask : t_self_prog
	task t_select(input int n, input logic [1:0] eif, input logic [5:0] own);
		int k;
		k = 0;
		u_prog.hold_reset(1'b1, 1'b0);
		chk(32'(prog_mode), 32'h1);
		chk(32'(port_def), 32'h1);
		u_prog.pulses(n);
		while (prog_if === 2'b00 && k < 100) begin
			@(posedge mclk);
			k++;
		end
		@(posedge mclk);
		#1;
		chk(32'(prog_if), 32'(eif));
		chk(32'(pin_owned), 32'(own));
		apb(1'b0, fmbc_pkg::ADDR_MODE_STAT, 32'h0);
		chk(32'(r[7:6]), 32'h1);
		u_prog.pulses(3);
		repeat (30) @(posedge mclk);
		#1;
		chk(32'(prog_if), 32'(eif));
	endtask : t_select
	task t_prohibited;
		u_prog.hold_reset(1'b1, 1'b1);
		repeat (30) @(posedge mclk);
		#1;
		chk(32'(prog_mode), 32'h0);
		chk(32'(pin_owned), 32'h0);
		apb(1'b0, fmbc_pkg::ADDR_MODE_STAT, 32'h0);
		chk(32'(r[2:1]), 32'(fmbc_pkg::MODE_BAD));
	endtask : t_prohibited
	// ----------------------------------------------------------------
	// main sequence and hang guard
	// ----------------------------------------------------------------
	// selection runs well under a thousand cycles, so this ceiling only trips on a hang
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 6000) begin
			error_cnt++;
			results();
		end
	end
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		opt = 8'hc3;
		t_normal();
		t_self_prog();
		t_select(int'(fmbc_pkg::PULSES_ASYNC), fmbc_pkg::IF_ASYNC, 6'h30);
		t_select(int'(fmbc_pkg::PULSES_SYNC), fmbc_pkg::IF_SYNC, 6'h0e);
		t_select(int'(fmbc_pkg::PULSES_SYNC_HS), fmbc_pkg::IF_SYNC_HS, 6'h0f);
		t_select(fmbc_pkg::MAX_MODE_PULSES, fmbc_pkg::IF_SYNC_HS, 6'h0f);
		t_select(fmbc_pkg::MAX_MODE_PULSES + 2, fmbc_pkg::IF_SYNC_HS, 6'h0f);
		t_prohibited();
		results();
	end
endmodule : fmbc_top_tb
`default_nettype wire
